//--- bottom_hold_defines.svh
// Constants of the bottom-hold self-timing judge
// Function
// - Bottom hold with internal timing opens periods from reading against threshold.
// - Outside a period, outputs and shown value stay unchanged.
// - End update: falling below threshold turns outputs off, starts minimum tracking.
// - End update: rising above threshold judges minimum, latches outputs, shows it.
// - Each later fall repeats tracking while the old shown value stays.
// - Continuous update refreshes shown minimum throughout the period, and outputs too once standby has cleared.
// - Continuous update clears shown value at period start, then shows running minimum.
// - Continuous update freezes shown value when the period ends and judges outputs from it.
// - Self-timing threshold is a user setting compared against the live reading.
// - Setting mode entered only after key held two seconds on main screen.
// - Peak-to-peak judges maximum minus minimum over the external timing period.
// - Internal self-timing is refused while peak-to-peak mode is selected.
// - After power-up or reset, standby shown and outputs off until first value.
// - Reset comes from the external reset input, or the key during error.
// - Peak-to-peak end update changes shown value and outputs only on timing events.
// - At timing rising edge, peak-to-peak shows held maximum minus minimum.
`ifndef BOTTOM_HOLD_DEFINES_SVH
`define BOTTOM_HOLD_DEFINES_SVH

`define READ_W 16
`define REF_CLK_KHZ 40000
`define KEY_HOLD_MS 2000
`define KEY_HOLD_CYCLES (`KEY_HOLD_MS * `REF_CLK_KHZ)
`define SHOWN_RST 16'h0000
`define SYNC_W 3

`endif

//--- bottom_hold_judge.sv
// Hold-and-judge logic: bottom hold self-timing, peak-to-peak, standby and key
`include "bottom_hold_defines.svh"

module bottom_hold_judge #(
	parameter int KEY_HOLD_CYCLES = `KEY_HOLD_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Live reading, same clock domain
	input wire logic [15:0] reading,
	// Settings
	input wire logic [15:0] self_timing_level,
	input wire logic [15:0] upper_limit,
	input wire logic [15:0] lower_limit,
	input wire logic mode_peak_to_peak,
	input wire logic update_continuous,
	input wire logic timing_external,
	// Panel state
	input wire logic main_screen,
	input wire logic error_shown,
	input wire logic setting_exit,
	// Pins from the controller and the panel
	input wire logic timing_pin,
	input wire logic reset_pin,
	input wire logic key_pin,
	// Judgement and display
	output logic [15:0] judged_value,
	output logic out_high,
	output logic out_go,
	output logic out_low,
	output logic standby_shown,
	output logic setting_mode,
	output logic self_timing_refused
);

	bottom_hold_pkg::judge_s st_q;
	bottom_hold_pkg::judge_s st_d;

	logic [2:0] pin_level;
	logic timing_lvl;
	logic rst_lvl;
	logic key_lvl;
	logic below;
	logic in_period;
	logic period_start;
	logic period_end;
	logic soft_rst;
	logic [15:0] min_run;
	logic [15:0] max_run;
	logic [15:0] span_run;
	logic [15:0] judge_in;
	logic [2:0] cls;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	pin_sync u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_raw({key_pin, reset_pin, timing_pin}),
		.pin_level(pin_level)
	);

	assign timing_lvl = pin_level[0];
	assign rst_lvl = pin_level[1];
	assign key_lvl = pin_level[2];

	// ----------------------------------------------------------------
	// Classifier
	// ----------------------------------------------------------------
	// limits to one output
	function automatic logic [2:0] classify(input logic [15:0] v, input logic [15:0] up,
		input logic [15:0] lo);
		logic [2:0] r;
		r = 3'h2;
		if (v > up) begin
			r = 3'h4;
		end else if (v < lo) begin
			r = 3'h1;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		soft_rst = (rst_lvl && !st_q.rst_prev) || (key_lvl && !st_q.key_prev && error_shown);
		below = reading < self_timing_level;
		in_period = (mode_peak_to_peak || timing_external) ? !timing_lvl : below;
		period_start = in_period && st_q.phase == bottom_hold_pkg::PH_IDLE;
		period_end = !in_period && st_q.phase == bottom_hold_pkg::PH_SAMPLE;
		min_run = (period_start || reading < st_q.min_val) ? reading : st_q.min_val;
		max_run = (period_start || reading > st_q.max_val) ? reading : st_q.max_val;
		span_run = max_run - min_run;
		judge_in = mode_peak_to_peak ? span_run : min_run;
		cls = classify(judge_in, upper_limit, lower_limit);

		st_d.timing_prev = timing_lvl;
		st_d.rst_prev = rst_lvl;
		st_d.key_prev = key_lvl;
		st_d.refused = mode_peak_to_peak;

		if (key_lvl && main_screen && !st_q.setting) begin
			if (st_q.key_cnt < 32'(KEY_HOLD_CYCLES)) begin
				st_d.key_cnt = st_q.key_cnt + 32'h00000001;
			end
		end else begin
			st_d.key_cnt = 32'h00000000;
		end
		if (st_q.key_cnt >= 32'(KEY_HOLD_CYCLES)) begin
			st_d.setting = 1'b1;
		end else if (setting_exit) begin
			st_d.setting = 1'b0;
		end

		if (soft_rst) begin
			st_d.phase = bottom_hold_pkg::PH_IDLE;
			st_d.standby = 1'b1;
			st_d.shown = `SHOWN_RST;
			st_d.hi = 1'b0;
			st_d.go = 1'b0;
			st_d.lo = 1'b0;
		end else if (st_q.phase == bottom_hold_pkg::PH_SAMPLE || period_start) begin
			if (!in_period) begin
				st_d.phase = bottom_hold_pkg::PH_IDLE;
				st_d.standby = 1'b0;
				if (!update_continuous) begin
					st_d.shown = mode_peak_to_peak ? st_q.max_val - st_q.min_val : st_q.min_val;
					{st_d.hi, st_d.go, st_d.lo} = classify(st_d.shown, upper_limit,
						lower_limit);
				end else begin
					// first period after standby judged too
					{st_d.hi, st_d.go, st_d.lo} = classify(st_q.shown, upper_limit,
						lower_limit);
				end
			end else begin
				st_d.phase = bottom_hold_pkg::PH_SAMPLE;
				st_d.min_val = min_run;
				st_d.max_val = max_run;
				if (update_continuous) begin
					st_d.shown = judge_in;
					{st_d.hi, st_d.go, st_d.lo} = st_q.standby ? 3'h0 : cls;
				end else if (period_start) begin
					{st_d.hi, st_d.go, st_d.lo} = 3'h0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q.phase <= bottom_hold_pkg::PH_IDLE;
			st_q.standby <= 1'b1;
			st_q.shown <= `SHOWN_RST;
			st_q.min_val <= 16'h0000;
			st_q.max_val <= 16'h0000;
			st_q.hi <= 1'b0;
			st_q.go <= 1'b0;
			st_q.lo <= 1'b0;
			st_q.key_cnt <= 32'h00000000;
			st_q.setting <= 1'b0;
			st_q.refused <= 1'b0;
			st_q.timing_prev <= 1'b0;
			st_q.rst_prev <= 1'b0;
			st_q.key_prev <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign judged_value = st_q.shown;
	assign out_high = st_q.hi;
	assign out_go = st_q.go;
	assign out_low = st_q.lo;
	assign standby_shown = st_q.standby;
	assign setting_mode = st_q.setting;
	assign self_timing_refused = st_q.refused;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic sampling;
	assign sampling = st_q.phase == bottom_hold_pkg::PH_SAMPLE;

	chk_standby_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
		st_q.standby |-> !(st_q.hi || st_q.go || st_q.lo))
		else $error("outputs on during standby");

	chk_judge_onehot: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(st_q.hi || st_q.go || st_q.lo) |-> $onehot({st_q.hi, st_q.go, st_q.lo}))
		else $error("more than one judgement output on");

	chk_end_start_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
		($rose(sampling) && !$past(update_continuous) && !$past(soft_rst))
		|-> !(st_q.hi || st_q.go || st_q.lo) && $stable(st_q.shown))
		else $error("period start did not clear outputs");

	chk_end_shown_kept: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(sampling && $past(sampling) && !$past(update_continuous) && !$past(soft_rst))
		|-> $stable(st_q.shown))
		else $error("shown value moved inside period");

	chk_end_latch_min: assert property (@(posedge ref_clk) disable iff (!reset_n)
		($fell(sampling) && !$past(update_continuous) && !$past(mode_peak_to_peak)
		&& !$past(soft_rst)) |-> st_q.shown == $past(st_q.min_val) && !st_q.standby)
		else $error("period end did not show minimum");

	chk_idle_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(!sampling && $past(!sampling) && !$past(soft_rst) && !$past(period_start))
		|-> $stable(st_q.shown) && $stable({st_q.hi, st_q.go, st_q.lo}))
		else $error("held result changed outside period");

	chk_cont_min: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(sampling && $past(sampling) && $past(update_continuous) && !$past(mode_peak_to_peak)
		&& !$past(soft_rst)) |-> st_q.shown <= $past(st_q.shown))
		else $error("running minimum rose");

	chk_pp_span: assert property (@(posedge ref_clk) disable iff (!reset_n)
		($fell(sampling) && !$past(update_continuous) && $past(mode_peak_to_peak)
		&& !$past(soft_rst)) |-> st_q.shown == $past(st_q.max_val - st_q.min_val))
		else $error("span not shown at period end");

	chk_key_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(st_q.setting) |-> $past(st_q.key_cnt) >= 32'(KEY_HOLD_CYCLES))
		else $error("setting mode entered too early");

	chk_reset_standby: assert property (@(posedge ref_clk) disable iff (!reset_n)
		soft_rst |=> st_q.standby && st_q.shown == `SHOWN_RST)
		else $error("soft reset ignored");

	// ----------------------------------------------------------------
	// Period source, judgement, reset and setting-mode checks
	// ----------------------------------------------------------------

	chk_pp_no_self: assert property (@(posedge ref_clk) disable iff (!reset_n)
		((mode_peak_to_peak || timing_external) && timing_lvl) |=> !sampling)
		else $error("period opened without timing input");

	chk_self_open: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(!mode_peak_to_peak && !timing_external && below && !soft_rst) |=> sampling)
		else $error("reading below threshold opened no period");

	chk_self_close: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(!mode_peak_to_peak && !timing_external && !below) |=> !sampling)
		else $error("reading above threshold kept period open");

	chk_refused_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
		self_timing_refused == $past(mode_peak_to_peak))
		else $error("refusal flag does not follow mode");

	chk_cont_outputs: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(sampling && $past(update_continuous) && !$past(st_q.standby) && !$past(soft_rst))
		|-> st_q.hi == (st_q.shown > $past(upper_limit))
		&& st_q.lo == (!st_q.hi && st_q.shown < $past(lower_limit))
		&& st_q.go == !(st_q.hi || st_q.lo))
		else $error("running outputs do not follow shown value");

	chk_close_classify: assert property (@(posedge ref_clk) disable iff (!reset_n)
		($fell(sampling) && !$past(update_continuous) && !$past(soft_rst))
		|-> $onehot({st_q.hi, st_q.go, st_q.lo})
		&& st_q.hi == (st_q.shown > $past(upper_limit))
		&& st_q.lo == (!st_q.hi && st_q.shown < $past(lower_limit)))
		else $error("period end judged wrongly");

	chk_pp_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		($changed(st_q.shown) && $past(mode_peak_to_peak) && !$past(update_continuous)
		&& !$past(soft_rst)) |-> $fell(sampling))
		else $error("span changed between timing events");

	chk_cont_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
		($rose(sampling) && $past(update_continuous) && !$past(mode_peak_to_peak)
		&& !$past(soft_rst)) |-> st_q.shown == $past(reading))
		else $error("held value not cleared at period start");

	chk_cont_freeze: assert property (@(posedge ref_clk) disable iff (!reset_n)
		($fell(sampling) && $past(update_continuous) && !$past(soft_rst))
		|-> $stable(st_q.shown) && !st_q.standby && $onehot({st_q.hi, st_q.go, st_q.lo}))
		else $error("continuous result not frozen at period end");

	chk_standby_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(st_q.standby) |-> $past(period_end) && !$past(soft_rst))
		else $error("standby left without a judged value");

	chk_soft_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
		soft_rst |=> !(st_q.hi || st_q.go || st_q.lo) && !sampling)
		else $error("soft reset left outputs on");

	chk_setting_exit: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(setting_exit && st_q.key_cnt < 32'(KEY_HOLD_CYCLES)) |=> !st_q.setting)
		else $error("setting mode not left on exit");

endmodule // bottom_hold_judge

//--- bottom_hold_judge_tb.sv
// Self-checking bench for the bottom-hold judge
module bottom_hold_judge_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [15:0] reading = 16'h00C8;
	logic mode_pp = 1'b0;
	logic upd_c = 1'b0;
	logic main_screen = 1'b0;
	logic setting_exit = 1'b0;
	logic error_shown = 1'b0;
	logic key_pin = 1'b0;
	logic period_req = 1'b0;
	logic reset_req = 1'b0;
	logic timing_pin;
	logic reset_pin;
	logic [15:0] judged_value;
	logic out_high;
	logic out_go;
	logic out_low;
	logic standby_shown;
	logic setting_mode;
	logic self_timing_refused;
	int fail_count = 0;
	int check_count = 0;
	int n;

	always #12.5 ref_clk = ~ref_clk;

	ctrl_model u_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .period_req(period_req),
		.reset_req(reset_req), .timing_pin(timing_pin), .reset_pin(reset_pin));

	bottom_hold_judge #(.KEY_HOLD_CYCLES(20)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.reading(reading), .self_timing_level(16'h0064), .upper_limit(16'h0050),
		.lower_limit(16'h0028), .mode_peak_to_peak(mode_pp), .update_continuous(upd_c),
		.timing_external(1'b0), .main_screen(main_screen), .error_shown(error_shown),
		.setting_exit(setting_exit), .timing_pin(timing_pin), .reset_pin(reset_pin),
		.key_pin(key_pin), .judged_value(judged_value), .out_high(out_high),
		.out_go(out_go), .out_low(out_low), .standby_shown(standby_shown),
		.setting_mode(setting_mode), .self_timing_refused(self_timing_refused));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic drive(input logic [15:0] v, input int cyc);
		@(posedge ref_clk);
		reading <= v;
		repeat (cyc) @(posedge ref_clk);
		#1;
	endtask

	task automatic outs(input logic [15:0] v, input logic [3:0] b);
		chk_val(judged_value, v);
		chk_bits({standby_shown, out_high, out_go, out_low}, b);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		drive(16'h00C8, 3);
		outs(16'h0000, 4'h8);
		drive(16'h003C, 3);
		outs(16'h0000, 4'h8);
		drive(16'h001E, 2);
		drive(16'h0032, 2);
		drive(16'h00C8, 3);
		outs(16'h001E, 4'h1);
		drive(16'h00C8, 5);
		outs(16'h001E, 4'h1);
		drive(16'h0046, 3);
		outs(16'h001E, 4'h0);
		drive(16'h00C8, 3);
		outs(16'h0046, 4'h2);
		$display("test end_update done");
		@(posedge ref_clk);
		upd_c <= 1'b1;
		drive(16'h005A, 3);
		outs(16'h005A, 4'h4);
		drive(16'h0032, 3);
		outs(16'h0032, 4'h2);
		drive(16'h00C8, 3);
		outs(16'h0032, 4'h2);
		$display("test continuous done");
		@(posedge ref_clk);
		upd_c <= 1'b0;
		mode_pp <= 1'b1;
		drive(16'h0014, 3);
		chk_bits({3'h0, self_timing_refused}, 4'h1);
		outs(16'h0032, 4'h2);
		period_req <= 1'b1;
		drive(16'h000A, 8);
		drive(16'h005F, 3);
		period_req <= 1'b0;
		drive(16'h005F, 8);
		outs(16'h0055, 4'h4);
		$display("test peak_to_peak done");
		reset_req <= 1'b1;
		drive(16'h005F, 8);
		outs(16'h0000, 4'h8);
		reset_req <= 1'b0;
		mode_pp <= 1'b0;
		main_screen <= 1'b1;
		key_pin <= 1'b1;
		drive(16'h00C8, 12);
		chk_bits({3'h0, setting_mode}, 4'h0);
		key_pin <= 1'b0;
		drive(16'h00C8, 8);
		key_pin <= 1'b1;
		n = 0;
		while (setting_mode !== 1'b1 && n < 60) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk_bits({3'h0, setting_mode}, 4'h1);
		chk_bits({3'h0, n >= 20}, 4'h1);
		key_pin <= 1'b0;
		setting_exit <= 1'b1;
		drive(16'h00C8, 3);
		chk_bits({3'h0, setting_mode}, 4'h0);
		outs(16'h005F, 4'h4);
		error_shown <= 1'b1;
		key_pin <= 1'b1;
		drive(16'h00C8, 8);
		outs(16'h0000, 4'h8);
		$display("test key_and_reset done");
		tally_and_finish();
	end
endmodule // bottom_hold_judge_tb

//--- bottom_hold_pkg.sv
// Types of the bottom-hold self-timing judge
package bottom_hold_pkg;

	typedef enum logic {
		PH_IDLE,
		PH_SAMPLE
	} phase_e;

	typedef struct packed {
		phase_e phase;
		logic standby;
		logic [15:0] shown;
		logic [15:0] min_val;
		logic [15:0] max_val;
		logic hi;
		logic go;
		logic lo;
		logic [31:0] key_cnt;
		logic setting;
		logic refused;
		logic timing_prev;
		logic rst_prev;
		logic key_prev;
	} judge_s;

endpackage

//--- ctrl_model.sv
// External controller model driving the timing and reset pins
module ctrl_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Requests from the bench
	input wire logic period_req,
	input wire logic reset_req,
	// Pins
	output logic timing_pin,
	output logic reset_pin
);
	timeunit 1ns;
	timeprecision 1ns;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timing_pin <= 1'b1;
			reset_pin <= 1'b0;
		end else begin
			timing_pin <= !period_req;
			reset_pin <= reset_req;
		end
	end
endmodule // ctrl_model

//--- pin_sync.sv
// Three-stage synchroniser with agreement filter for the pin inputs
module pin_sync (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Raw pins and filtered levels
	input wire logic [2:0] pin_raw,
	output logic [2:0] pin_level
);

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] level;
	} sync_s;

	sync_s st_q;
	sync_s st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = pin_raw;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < 3; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.level[i] = st_q.s3[i];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pin_level = st_q.level;

endmodule // pin_sync
